// >>> hw/csb_sideband.sv
// Sideband logic: internal error, numeric error, init, irq pins, lock
`timescale 1ns/1ns
`default_nettype none
module csb_sideband (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Core error and numeric status
   input wire logic internal_error_detect_in,
   input wire logic fp_error_pending_in,
   input wire logic fp_noncontrol_issue_in,
   input wire logic native_numeric_error_enable_in,
   // Asynchronous pins
   input wire logic ignore_numeric_error_n_in,
   input wire logic soft_init_n_in,
   input wire logic [1:0] local_irq_pins_in,
   // Local interrupt controller configuration
   input wire logic lic_cfg_write_in,
   input wire logic lic_cfg_enable_in,
   // Lock sequencing from the core and the lock wire level
   input wire logic lock_seq_start_in,
   input wire logic lock_seq_end_in,
   input wire logic lock_n_pin_in,
   // Error outputs
   output logic internal_error_n_out,
   output logic shutdown_req_out,
   output logic fp_exception_out,
   // Init outputs
   output logic int_reg_reset_out,
   output logic fetch_reset_vector_out,
   output logic snoop_enable_out,
   output logic self_test_out,
   // Interrupt outputs
   output logic lic_enabled_out,
   output logic [1:0] lic_irq_out,
   output logic maskable_irq_out,
   output logic nmi_out,
   // Lock pin
   output logic lock_n_pin_out,
   output logic lock_n_pin_oe_out,
   output logic lock_seen_out
);
   // ==========================================================
   // Synchronisers
   logic [4:0] raw_async;
   logic [4:0] sync_vec;
   logic ign_sync;
   logic init_sync;
   logic [1:0] lirq_sync;
   logic lock_sync;

   assign raw_async = {~lock_n_pin_in, local_irq_pins_in,
                       ~soft_init_n_in, ~ignore_numeric_error_n_in};

   csb_sync2 #(
      .WIDTH(5)
   ) u_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .async_in(raw_async),
      .sync_out(sync_vec)
   );

   assign ign_sync = sync_vec[0];
   assign init_sync = sync_vec[1];
   assign lirq_sync = sync_vec[3:2];
   assign lock_sync = sync_vec[4];

   // ==========================================================
   // State
   typedef enum logic [2:0] {
      CSB_RST = 3'b001,
      CSB_RUN = 3'b010,
      CSB_INIT = 3'b100
   } csb_state_e;

   csb_state_e state_reg;
   csb_state_e state_next;
   logic internal_error_out_reg;
   logic internal_error_out_next;
   logic [3:0] shut_cnt_reg;
   logic [3:0] shut_cnt_next;
   logic shut_reg;
   logic shut_next;
   logic fpx_reg;
   logic fpx_next;
   logic intrst_reg;
   logic intrst_next;
   logic fetch_reg;
   logic fetch_next;
   logic bist_reg;
   logic bist_next;
   logic lic_en_reg;
   logic lic_en_next;
   logic [1:0] lic_irq_reg;
   logic [1:0] lic_irq_next;
   logic maskable_irq_reg;
   logic maskable_irq_next;
   logic nmi_reg;
   logic nmi_next;
   logic lock_drv_reg;
   logic lock_drv_next;
   logic lock_seen_reg;
   logic lock_seen_next;
   logic ignore_eff;

   always_comb
   begin
      state_next = state_reg;
      internal_error_out_next = internal_error_out_reg;
      shut_cnt_next = shut_cnt_reg;
      shut_next = 1'b0;
      intrst_next = 1'b0;
      fetch_next = 1'b0;
      bist_next = bist_reg;
      lic_en_next = lic_en_reg;
      lock_drv_next = lock_drv_reg;
      if (internal_error_detect_in)
      begin
         internal_error_out_next = 1'b1;
      end
      if (internal_error_detect_in && !internal_error_out_reg)
      begin
         shut_cnt_next = csb_pkg::SHUTDOWN_HOLD;
      end
      else if (shut_cnt_reg != 4'h0)
      begin
         shut_cnt_next = shut_cnt_reg - 4'h1;
      end
      if (shut_cnt_reg != 4'h0)
      begin
         shut_next = 1'b1;
      end
      ignore_eff = ign_sync && !native_numeric_error_enable_in;
      fpx_next = fp_noncontrol_issue_in && fp_error_pending_in &&
                 !ignore_eff;
      unique case (state_reg)
         CSB_RST:
         begin
            bist_next = init_sync;
            state_next = CSB_RUN;
         end
         CSB_RUN:
         begin
            bist_next = 1'b0;
            if (init_sync)
            begin
               state_next = CSB_INIT;
            end
         end
         CSB_INIT:
         begin
            intrst_next = 1'b1;
            if (!init_sync)
            begin
               fetch_next = 1'b1;
               intrst_next = 1'b0;
               state_next = CSB_RUN;
            end
         end
      endcase
      if (lic_cfg_write_in)
      begin
         lic_en_next = lic_cfg_enable_in;
      end
      lic_irq_next = lic_en_reg ? lirq_sync : 2'h0;
      maskable_irq_next = !lic_en_reg && lirq_sync[csb_pkg::LIRQ_MASKABLE_BIT];
      nmi_next = !lic_en_reg && lirq_sync[csb_pkg::LIRQ_NMI_BIT];
      if (lock_seq_start_in)
      begin
         lock_drv_next = 1'b1;
      end
      else if (lock_seq_end_in)
      begin
         lock_drv_next = 1'b0;
      end
      // show line state to partner logic
      lock_seen_next = lock_sync;
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= CSB_RST;
         internal_error_out_reg <= csb_pkg::INT_ERR_RESET;
         shut_cnt_reg <= 4'h0;
         shut_reg <= 1'b0;
         fpx_reg <= 1'b0;
         intrst_reg <= 1'b0;
         fetch_reg <= 1'b0;
         bist_reg <= 1'b0;
         lic_en_reg <= csb_pkg::LIC_EN_RESET;
         lic_irq_reg <= 2'h0;
         maskable_irq_reg <= 1'b0;
         nmi_reg <= 1'b0;
         lock_drv_reg <= 1'b0;
         lock_seen_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         internal_error_out_reg <= internal_error_out_next;
         shut_cnt_reg <= shut_cnt_next;
         shut_reg <= shut_next;
         fpx_reg <= fpx_next;
         intrst_reg <= intrst_next;
         fetch_reg <= fetch_next;
         bist_reg <= bist_next;
         lic_en_reg <= lic_en_next;
         lic_irq_reg <= lic_irq_next;
         maskable_irq_reg <= maskable_irq_next;
         nmi_reg <= nmi_next;
         lock_drv_reg <= lock_drv_next;
         lock_seen_reg <= lock_seen_next;
      end
   end

   // ==========================================================
   // Outputs
   assign internal_error_n_out = ~internal_error_out_reg;
   assign shutdown_req_out = shut_reg;
   assign fp_exception_out = fpx_reg;
   assign int_reg_reset_out = intrst_reg;
   assign fetch_reset_vector_out = fetch_reg;
   assign snoop_enable_out = 1'b1;
   assign self_test_out = bist_reg;
   assign lic_enabled_out = lic_en_reg;
   assign lic_irq_out = lic_irq_reg;
   assign maskable_irq_out = maskable_irq_reg;
   assign nmi_out = nmi_reg;
   assign lock_n_pin_out = 1'b0;
   assign lock_n_pin_oe_out = lock_drv_reg;
   assign lock_seen_out = lock_seen_reg;

   // ==========================================================
   // Assertions
   default clocking cb_main @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_err_seen;
      internal_error_detect_in;
   endsequence

   sequence s_err_out;
      ##1 !internal_error_n_out;
   endsequence

   a_internal_error_out_raise: assert property (s_err_seen |-> s_err_out)
      else $error("internal error not raised");
   a_internal_error_out_sticky: assert property (
      !internal_error_n_out |=> !internal_error_n_out)
      else $error("internal error cleared without reset");
   a_internal_error_out_shutdown: assert property (
      (internal_error_detect_in && internal_error_n_out) |-> ##2
      shutdown_req_out)
      else $error("no shutdown after internal error");
   a_fp_ignore: assert property (
      (ign_sync && !native_numeric_error_enable_in) |=> !fp_exception_out)
      else $error("exception while ignoring");
   a_fp_raise: assert property (
      (fp_noncontrol_issue_in && fp_error_pending_in && !ign_sync) |=>
      fp_exception_out)
      else $error("pending numeric exception missed");
   a_fp_native: assert property (
      (fp_noncontrol_issue_in && fp_error_pending_in &&
      native_numeric_error_enable_in) |=> fp_exception_out)
      else $error("ignore input honoured under native enable");
   a_init_fetch: assert property (
      (state_reg == CSB_INIT && !init_sync) |=>
      (fetch_reset_vector_out && !int_reg_reset_out))
      else $error("no reset vector fetch after init");
   a_init_hold: assert property (
      (state_reg == CSB_INIT && init_sync) |=> int_reg_reset_out)
      else $error("integer reset not held");
   a_bist_sample: assert property (
      (state_reg == CSB_RST) |=> (self_test_out == $past(init_sync)))
      else $error("self-test sample wrong");
   a_lic_route: assert property (
      !lic_en_reg |=> (maskable_irq_out == $past(lirq_sync[0]) &&
      nmi_out == $past(lirq_sync[1])))
      else $error("legacy irq routing wrong");
   a_lic_default: assert property (
      $rose(rst_n_in) |-> lic_enabled_out)
      else $error("controller not enabled after reset");
   a_lock_hold: assert property (
      lock_seq_start_in |=> lock_n_pin_oe_out)
      else $error("lock not driven at sequence start");
   a_lock_keep: assert property (
      (lock_n_pin_oe_out && !lock_seq_end_in) |=> lock_n_pin_oe_out)
      else $error("lock dropped inside sequence");
   a_lock_free: assert property (
      (lock_seq_end_in && !lock_seq_start_in) |=> !lock_n_pin_oe_out)
      else $error("lock held after sequence end");
endmodule
`default_nettype wire

// >>> shared/csb_pkg.sv
// Package of constants for the sideband error, init and lock block
package csb_pkg;
   // ==========================================================
   // Reset values of sticky and mode state
   localparam logic INT_ERR_RESET = 1'b0;
   localparam logic LIC_EN_RESET = 1'b1;
   // ==========================================================
   // Synchroniser depth and bit positions of the local irq pins
   localparam int SYNC_STAGES = 2;
   localparam int LIRQ_MASKABLE_BIT = 0;
   localparam int LIRQ_NMI_BIT = 1;
   // ==========================================================
   // Cycles the shutdown request is held on the core side
   localparam logic [3:0] SHUTDOWN_HOLD = 4'h1;
endpackage

// >>> hw/csb_sync2.sv
// Two-flop synchroniser for asynchronous sideband inputs
`timescale 1ns/1ns
`default_nettype none
module csb_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb
   begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // Flops keep sampling in reset so pin levels are current at release
   always_ff @(posedge clock_in)
   begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
   end

   assign sync_out = sync_reg;
endmodule
`default_nettype wire

// >>> tb/csb_partner.sv
// Far-side model: other lock agent and a priority bus agent
`timescale 1ns/1ns
`default_nettype none
module csb_partner (
   // Clock and lock wire
   input wire logic clock_in,
   input wire logic lock_wire_in,
   // Commands from the bench
   input wire logic prio_req_in,
   input wire logic other_lock_in,
   // Outputs
   output logic lock_drive_out,
   output var logic prio_owner_out
);
   // ==========================================
   // Lock drive of the other agent
   // shared lock hold
   assign lock_drive_out = other_lock_in;
   always_ff @(posedge clock_in)
   begin
      prio_owner_out <= prio_req_in & (prio_owner_out | lock_wire_in);
   end
endmodule
`default_nettype wire

// >>> tb/cpu_sideband_error_init_lock_tb.sv
// Bench for the sideband error, init and lock block
`timescale 1ns/1ns
`default_nettype none
module cpu_sideband_error_init_lock_tb;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic err_det = 1'b0, fp_pend = 1'b0, fp_issue = 1'b0, native = 1'b0;
   logic ign_n = 1'b1, init_n = 1'b1, cfg_wr = 1'b0, cfg_en = 1'b1;
   logic lk_start = 1'b0, lk_end = 1'b0, other = 1'b0, prio_req = 1'b0;
   logic [1:0] pins = 2'h0;
   logic [1:0] lic_irq;
   logic internal_error_out_n, shut, fpx, irr, fetch, snoop, bist, lic_en, mirq, nmi;
   logic lk_out, lk_oe, lk_seen, lock_wire, other_drv, prio_own;
   int errors = 0;
   int check_count = 0;
   // ==========================================
   // Clock, wire level and instances
   always #50 clock_in = ~clock_in;
   assign lock_wire = ~((lk_oe & ~lk_out) | other_drv);
   csb_sideband csb_sideband_inst (.clock_in(clock_in),
      .rst_n_in(rst_n_in), .internal_error_detect_in(err_det),
      .fp_error_pending_in(fp_pend), .fp_noncontrol_issue_in(fp_issue),
      .native_numeric_error_enable_in(native),
      .ignore_numeric_error_n_in(ign_n), .soft_init_n_in(init_n),
      .local_irq_pins_in(pins), .lic_cfg_write_in(cfg_wr),
      .lic_cfg_enable_in(cfg_en), .lock_seq_start_in(lk_start),
      .lock_seq_end_in(lk_end), .lock_n_pin_in(lock_wire),
      .internal_error_n_out(internal_error_out_n), .shutdown_req_out(shut),
      .fp_exception_out(fpx), .int_reg_reset_out(irr),
      .fetch_reset_vector_out(fetch), .snoop_enable_out(snoop),
      .self_test_out(bist), .lic_enabled_out(lic_en),
      .lic_irq_out(lic_irq), .maskable_irq_out(mirq), .nmi_out(nmi),
      .lock_n_pin_out(lk_out), .lock_n_pin_oe_out(lk_oe),
      .lock_seen_out(lk_seen));
   csb_partner csb_partner_inst (.clock_in(clock_in),
      .lock_wire_in(lock_wire), .prio_req_in(prio_req),
      .other_lock_in(other), .lock_drive_out(other_drv),
      .prio_owner_out(prio_own));
   // ==========================================
   // Shared tasks
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge clock_in);
         #10;
      end
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s exp %b got %b", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset();
      rst_n_in = 1'b0;
      step(3);
      rst_n_in = 1'b1;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_fp(input logic ign, input logic nat, input logic exp);
      // ignore pin stable over the issue
      ign_n = ign;
      native = nat;
      fp_pend = 1'b1;
      step(3);
      fp_issue = 1'b1;
      step(1);
      fp_issue = 1'b0;
      chk("fpx", exp, fpx);
      step(1);
      chk("fpx_end", 1'b0, fpx);
      ign_n = 1'b1;
   endtask
   task automatic t_irq();
      pins = 2'h2;
      step(3);
      chk("lic_irq1", 1'b1, lic_irq[1]);
      chk("nmi_off", 1'b0, nmi);
      cfg_en = 1'b0;
      cfg_wr = 1'b1;
      step(1);
      cfg_wr = 1'b0;
      chk("lic_off", 1'b0, lic_en);
      for (int i = 1; i < 3; i++)
      begin
         pins = 2'(i);
         step(3);
         chk("maskable", pins[0], mirq);
         chk("nmi", pins[1], nmi);
         chk("lic_irq", 1'b0, lic_irq[0] | lic_irq[1]);
      end
      pins = 2'h0;
   endtask
   task automatic t_init();
      int k;
      init_n = 1'b0;
      step(3);
      chk("irr_early", 1'b0, irr);
      step(1);
      chk("irr", 1'b1, irr);
      chk("snoop", 1'b1, snoop);
      init_n = 1'b1;
      k = 0;
      while (fetch !== 1'b1 && k < 6)
      begin
         step(1);
         k++;
      end
      if (fetch !== 1'b1)
      begin
         errors++;
         complete_run();
      end
      chk("irr_rel", 1'b0, irr);
      step(1);
      chk("fetch_end", 1'b0, fetch);
   endtask
   task automatic t_lock();
      lk_start = 1'b1;
      step(1);
      lk_start = 1'b0;
      prio_req = 1'b1;
      chk("lock_oe", 1'b1, lk_oe);
      chk("lock_lvl", 1'b0, lk_out);
      step(3);
      chk("lock_seen", 1'b1, lk_seen);
      chk("prio_wait", 1'b0, prio_own);
      lk_end = 1'b1;
      step(1);
      lk_end = 1'b0;
      chk("lock_rel", 1'b0, lk_oe);
      step(1);
      chk("prio_own", 1'b1, prio_own);
      other = 1'b1;
      step(3);
      chk("seen_other", 1'b1, lk_seen);
      other = 1'b0;
      prio_req = 1'b0;
   endtask
   task automatic t_error();
      err_det = 1'b1;
      step(1);
      err_det = 1'b0;
      chk("internal_error_out_n", 1'b0, internal_error_out_n);
      step(1);
      chk("shut", 1'b1, shut);
      step(1);
      chk("shut_end", 1'b0, shut);
      err_det = 1'b1;
      repeat (4)
      begin
         step(1);
         chk("shut_rpt", 1'b0, shut);
      end
      err_det = 1'b0;
      step(20);
      chk("internal_error_out_hold", 1'b0, internal_error_out_n);
      do_reset();
      chk("internal_error_out_clr", 1'b1, internal_error_out_n);
   endtask
   task automatic t_bist();
      init_n = 1'b0;
      do_reset();
      step(1);
      chk("bist", 1'b1, bist);
      step(1);
      chk("bist_end", 1'b0, bist);
      init_n = 1'b1;
      step(6);
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      do_reset();
      step(1);
      chk("rst_internal_error_out", 1'b1, internal_error_out_n);
      chk("rst_lic", 1'b1, lic_en);
      chk("rst_oe", 1'b0, lk_oe);
      chk("rst_bist", 1'b0, bist);
      t_irq();
      t_fp(1'b1, 1'b0, 1'b1);
      t_fp(1'b0, 1'b0, 1'b0);
      t_fp(1'b0, 1'b1, 1'b1);
      t_init();
      t_lock();
      t_error();
      t_bist();
      complete_run();
   end
endmodule
`default_nettype wire
